/* File: hw/cpm_pkg.sv */
// Shared constants and types for the control port pin mode block.
//------------------------------------------------------------------------
// What this block does
// [RULE1] SCL input in I2C, open-collector output self-booting.
// [RULE2] SPI clock input, may stop between transactions.
// [RULE3] I2C SDA open-collector, drives low only.
// [RULE4] SPI read data returned on control_read_out.
// [RULE5] control_read_out released unless SPI read active.
// [RULE6] Both bus id straps form I2C slave address.
// [RULE7] SPI write data sampled on bus_id_high pin.
// [RULE8] SPI transactions of any length accepted.
// [RULE9] Boot strap high at reset starts self-boot.
// [RULE10] Output clock rate chosen by two select straps.
// [RULE11] Host frames each SPI transaction with latch low.
// [RULE12] bus_id_low tells two SPI devices apart.
//------------------------------------------------------------------------
package cpm_pkg;

   // Operating mode of the control port pins.
   typedef enum logic [1:0] {
      CPM_WAIT_STRAPS,
      CPM_SELF_BOOT,
      CPM_HOST_CTRL
   } cpm_mode_e;

   // Bit positions inside the synchronised pin vector.
   localparam int CPM_PIN_W = 8;
   localparam int CPM_PIN_SCL = 0;
   localparam int CPM_PIN_SDA = 1;
   localparam int CPM_PIN_LATCH = 2;
   localparam int CPM_PIN_ID_HI = 3;
   localparam int CPM_PIN_ID_LO = 4;
   localparam int CPM_PIN_BOOT = 5;
   localparam int CPM_PIN_CSEL_LO = 6;
   localparam int CPM_PIN_CSEL_HI = 7;

   // Default address bases; both values are arbitrary.
   localparam logic [6:0] CPM_I2C_ADDR_BASE = 7'h38;
   localparam logic [6:0] CPM_SPI_ID_BASE = 7'h14;

   // SPI framing: last bit index of a byte, byte indices within a frame.
   localparam logic [2:0] CPM_BIT_LAST = 3'h7;
   localparam logic [1:0] CPM_BYTE_CHIP = 2'h0;
   localparam logic [1:0] CPM_BYTE_ADDR_LO = 2'h2;
   localparam logic [1:0] CPM_BYTE_DATA = 2'h3;

   // Output clock divider counter width; select picks a counter bit.
   localparam int CPM_DIV_W = 4;
   localparam logic [1:0] CPM_DIV_BASE = 2'h0;

endpackage

/* File: hw/cpm_sync2.sv */
// Two flip-flop synchroniser for a vector of asynchronous pins.
`timescale 1ns/1ps

module cpm_sync2 #(
   parameter int WIDTH = 1
) (
   // Clock.
   input wire logic mclk,
   // Asynchronous levels in, synchronised levels out.
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // First stage; read only by the second stage below.
   logic [WIDTH-1:0] meta_ff;

   //---------------------------------------------------------------------
   // Synchroniser stages
   //---------------------------------------------------------------------
   // No reset here: the stages carry data only and settle within two
   // clocks, which lets the straps be valid right at reset release.
   always_ff @(posedge mclk)
   begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
   end

endmodule

/* File: hw/cpm_control_port.sv */
// Control port pin mode switching between I2C, SPI and self-boot.
`timescale 1ns/1ps

module cpm_control_port
   import cpm_pkg::*;
#(
   parameter logic [6:0] I2C_ADDR_BASE = CPM_I2C_ADDR_BASE,
   parameter logic [6:0] SPI_ID_BASE = CPM_SPI_ID_BASE
) (
   // Clock and synchronous reset.
   input wire logic mclk,
   input wire logic rst,
   // SCL / control_serial_clock pin.
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   // SDA / control_read_out pin.
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Control and strap pins.
   input wire logic control_latch,
   input wire logic bus_id_high,
   input wire logic bus_id_low,
   input wire logic boot_from_eeprom_select,
   input wire logic out_clock_sel_hi,
   input wire logic out_clock_sel_lo,
   // Output clock.
   output logic buffered_clock_out,
   // Core side: mode control and status.
   input wire logic spi_mode_sel,
   input wire logic boot_done,
   output logic mode_boot,
   output logic mode_i2c,
   output logic mode_spi,
   output logic boot_start,
   // Core side: I2C engines.
   input wire logic boot_scl_low,
   input wire logic boot_sda_low,
   input wire logic slave_sda_low,
   output logic [6:0] i2c_address,
   output logic scl_level,
   output logic sda_level,
   // Core side: SPI transfer.
   input wire logic [7:0] spi_rd_data,
   output logic spi_rd_take,
   output logic spi_selected,
   output logic spi_read,
   output logic spi_byte_valid,
   output logic [7:0] spi_byte,
   output logic spi_frame_end
);

   // Synchronised pins.
   logic [CPM_PIN_W-1:0] pin_s;
   // Strap capture state.
   logic straps_taken_ff, nxt_straps_taken;
   logic boot_strap_ff, nxt_boot_strap;
   logic [1:0] csel_ff, nxt_csel;
   logic [6:0] i2c_addr_ff, nxt_i2c_addr;
   // Mode state.
   cpm_mode_e mode_ff, nxt_mode;
   logic boot_start_ff, nxt_boot_start;
   // SPI state.
   logic clk_d_ff, latch_d_ff;
   logic [2:0] bit_cnt_ff, nxt_bit_cnt;
   logic [1:0] byte_cnt_ff, nxt_byte_cnt;
   logic [7:0] in_sh_ff, nxt_in_sh;
   logic [7:0] out_sh_ff, nxt_out_sh;
   logic sel_ff, nxt_sel;
   logic rd_ff, nxt_rd;
   logic rd_act_ff, nxt_rd_act;
   logic out_bit_ff, nxt_out_bit;
   logic byte_valid_ff, nxt_byte_valid;
   logic [7:0] byte_ff, nxt_byte;
   logic take_ff, nxt_take;
   logic end_ff, nxt_end;
   // Pin drive state.
   logic scl_oe_ff, nxt_scl_oe;
   logic sda_oe_ff, nxt_sda_oe;
   logic sda_out_ff, nxt_sda_out;
   // Output clock divider.
   logic [CPM_DIV_W-1:0] div_ff, nxt_div;
   logic clk_out_ff, nxt_clk_out;
   // Edge events of the SPI clock and the latch.
   logic clk_rise, clk_fall, latch_rise;
   logic [7:0] new_byte;

   //---------------------------------------------------------------------
   // Pin synchronisation
   //---------------------------------------------------------------------
   // Every pin is asynchronous to mclk, so all pass two flops first.
   cpm_sync2 #(
      .WIDTH(CPM_PIN_W)
   ) u_sync (
      .mclk(mclk),
      .async_in({out_clock_sel_hi, out_clock_sel_lo,
                 boot_from_eeprom_select, bus_id_low, bus_id_high,
                 control_latch, sda_in, scl_in}),
      .sync_out(pin_s)
   );

   //---------------------------------------------------------------------
   // Strap capture
   //---------------------------------------------------------------------
   // Straps are caught once, in the first clock after reset release,
   // because the id pin is reused as SPI data afterwards.
   always_comb
   begin
      nxt_straps_taken = 1'b1;
      nxt_boot_strap = boot_strap_ff;
      nxt_csel = csel_ff;
      nxt_i2c_addr = i2c_addr_ff;
      if (!straps_taken_ff)
      begin
         nxt_boot_strap = pin_s[CPM_PIN_BOOT];
         nxt_csel = {pin_s[CPM_PIN_CSEL_HI], pin_s[CPM_PIN_CSEL_LO]};
         // Low two address bits come from the id straps.
         nxt_i2c_addr = {I2C_ADDR_BASE[6:2], pin_s[CPM_PIN_ID_HI],
                         pin_s[CPM_PIN_ID_LO]}; // see [RULE6]
      end
   end

   // Registers of the strap group.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         straps_taken_ff <= 1'b0;
         boot_strap_ff <= 1'b0;
         csel_ff <= 2'h0;
         i2c_addr_ff <= 7'h00;
      end
      else
      begin
         straps_taken_ff <= nxt_straps_taken;
         boot_strap_ff <= nxt_boot_strap;
         csel_ff <= nxt_csel;
         i2c_addr_ff <= nxt_i2c_addr;
      end
   end

   //---------------------------------------------------------------------
   // Mode selection
   //---------------------------------------------------------------------
   // Self-boot runs once after reset when the strap was high, then the
   // port is handed to the host.
   always_comb
   begin
      nxt_mode = mode_ff;
      nxt_boot_start = 1'b0;
      case (mode_ff)
         CPM_WAIT_STRAPS:
         begin
            if (straps_taken_ff)
            begin
               if (boot_strap_ff)
               begin
                  nxt_mode = CPM_SELF_BOOT; // see [RULE9]
                  nxt_boot_start = 1'b1;
               end
               else
               begin
                  nxt_mode = CPM_HOST_CTRL; // see [RULE9]
               end
            end
         end
         CPM_SELF_BOOT:
         begin
            if (boot_done)
            begin
               nxt_mode = CPM_HOST_CTRL;
            end
         end
         CPM_HOST_CTRL:
         begin
            nxt_mode = CPM_HOST_CTRL;
         end
         default:
         begin
            nxt_mode = CPM_WAIT_STRAPS;
         end
      endcase
   end

   // Registers of the mode group.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         mode_ff <= CPM_WAIT_STRAPS;
         boot_start_ff <= 1'b0;
      end
      else
      begin
         mode_ff <= nxt_mode;
         boot_start_ff <= nxt_boot_start;
      end
   end

   //---------------------------------------------------------------------
   // SPI slave front end
   //---------------------------------------------------------------------
   // Edges are found from the synchronised clock only, so a clock that
   // stops between frames is harmless; the latch alone ends a frame.
   assign clk_rise = pin_s[CPM_PIN_SCL] && !clk_d_ff; // see [RULE2]
   assign clk_fall = !pin_s[CPM_PIN_SCL] && clk_d_ff;
   assign latch_rise = pin_s[CPM_PIN_LATCH] && !latch_d_ff;
   assign new_byte = {in_sh_ff[6:0], pin_s[CPM_PIN_ID_HI]}; // see [RULE7]

   // Next state of the SPI group.
   always_comb
   begin
      nxt_bit_cnt = bit_cnt_ff;
      nxt_byte_cnt = byte_cnt_ff;
      nxt_in_sh = in_sh_ff;
      nxt_out_sh = out_sh_ff;
      nxt_sel = sel_ff;
      nxt_rd = rd_ff;
      nxt_rd_act = rd_act_ff;
      nxt_out_bit = out_bit_ff;
      nxt_byte = byte_ff;
      nxt_byte_valid = 1'b0;
      nxt_take = 1'b0;
      nxt_end = mode_spi && latch_rise; // see [RULE11]
      if (pin_s[CPM_PIN_LATCH] || !mode_spi)
      begin
         // Latch high or SPI mode off: frame over, counters and select/read flags return to idle.
         nxt_bit_cnt = 3'h0;
         nxt_byte_cnt = CPM_BYTE_CHIP;
         nxt_sel = 1'b0;
         nxt_rd = 1'b0;
         nxt_rd_act = 1'b0;
      end
      else if (clk_rise)
      begin
         // Frame length is set by the latch, not by a fixed count.
         nxt_in_sh = new_byte; // see [RULE8]
         nxt_bit_cnt = bit_cnt_ff + 3'h1;
         if (bit_cnt_ff == CPM_BIT_LAST)
         begin
            if (byte_cnt_ff == CPM_BYTE_CHIP)
            begin
               // Only the id matching bus_id_low is this device.
               nxt_sel = (new_byte[7:1] == {SPI_ID_BASE[6:1],
                          pin_s[CPM_PIN_ID_LO]}); // see [RULE12]
               nxt_rd = new_byte[0];
               nxt_byte_cnt = byte_cnt_ff + 2'h1;
            end
            else
            begin
               if (byte_cnt_ff != CPM_BYTE_DATA)
               begin
                  nxt_byte_cnt = byte_cnt_ff + 2'h1;
               end
               if (sel_ff && !rd_act_ff)
               begin
                  nxt_byte = new_byte;
                  nxt_byte_valid = 1'b1;
               end
               // After the address, a read streams bytes from the core.
               if (sel_ff && rd_ff &&
                   (byte_cnt_ff == CPM_BYTE_ADDR_LO || rd_act_ff))
               begin
                  nxt_rd_act = 1'b1;
                  nxt_out_sh = spi_rd_data; // see [RULE4]
                  nxt_take = 1'b1;
               end
            end
         end
      end
      else if (clk_fall && rd_act_ff)
      begin
         // Data changes on the falling edge, MSB first.
         nxt_out_bit = out_sh_ff[7]; // see [RULE4]
         nxt_out_sh = {out_sh_ff[6:0], 1'b0};
      end
   end

   // Registers of the SPI group.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         clk_d_ff <= 1'b0;
         latch_d_ff <= 1'b1;
         bit_cnt_ff <= 3'h0;
         byte_cnt_ff <= CPM_BYTE_CHIP;
         in_sh_ff <= 8'h00;
         out_sh_ff <= 8'h00;
         sel_ff <= 1'b0;
         rd_ff <= 1'b0;
         rd_act_ff <= 1'b0;
         out_bit_ff <= 1'b0;
         byte_ff <= 8'h00;
         byte_valid_ff <= 1'b0;
         take_ff <= 1'b0;
         end_ff <= 1'b0;
      end
      else
      begin
         clk_d_ff <= pin_s[CPM_PIN_SCL];
         latch_d_ff <= pin_s[CPM_PIN_LATCH];
         bit_cnt_ff <= nxt_bit_cnt;
         byte_cnt_ff <= nxt_byte_cnt;
         in_sh_ff <= nxt_in_sh;
         out_sh_ff <= nxt_out_sh;
         sel_ff <= nxt_sel;
         rd_ff <= nxt_rd;
         rd_act_ff <= nxt_rd_act;
         out_bit_ff <= nxt_out_bit;
         byte_ff <= nxt_byte;
         byte_valid_ff <= nxt_byte_valid;
         take_ff <= nxt_take;
         end_ff <= nxt_end;
      end
   end

   //---------------------------------------------------------------------
   // Pin drivers
   //---------------------------------------------------------------------
   // Open-collector lines only ever drive zero; the enable carries the
   // data. Only SPI read data drives the shared pin actively high.
   always_comb
   begin
      nxt_scl_oe = 1'b0; // see [RULE1]
      nxt_sda_oe = 1'b0;
      nxt_sda_out = 1'b0; // see [RULE3]
      if (mode_ff == CPM_SELF_BOOT)
      begin
         nxt_scl_oe = boot_scl_low; // see [RULE1]
         nxt_sda_oe = boot_sda_low; // see [RULE3]
      end
      else if (mode_ff == CPM_HOST_CTRL && spi_mode_sel)
      begin
         nxt_sda_oe = nxt_rd_act; // see [RULE5]
         nxt_sda_out = nxt_out_bit; // see [RULE4]
      end
      else if (mode_ff == CPM_HOST_CTRL)
      begin
         nxt_sda_oe = slave_sda_low; // see [RULE3]
      end
   end

   // Registers of the pin group.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         scl_oe_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
         sda_out_ff <= 1'b0;
      end
      else
      begin
         scl_oe_ff <= nxt_scl_oe;
         sda_oe_ff <= nxt_sda_oe;
         sda_out_ff <= nxt_sda_out;
      end
   end

   //---------------------------------------------------------------------
   // Output clock
   //---------------------------------------------------------------------
   // Divide mclk by 2, 4, 8 or 16 by tapping one counter bit.
   always_comb
   begin
      nxt_div = div_ff + {{(CPM_DIV_W-1){1'b0}}, 1'b1};
      nxt_clk_out = div_ff[csel_ff + CPM_DIV_BASE]; // see [RULE10]
   end

   // Registers of the clock group.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         div_ff <= '0;
         clk_out_ff <= 1'b0;
      end
      else
      begin
         div_ff <= nxt_div;
         clk_out_ff <= nxt_clk_out;
      end
   end

   //---------------------------------------------------------------------
   // Outputs
   //---------------------------------------------------------------------
   assign scl_out = 1'b0;
   assign scl_oe = scl_oe_ff;
   assign sda_out = sda_out_ff;
   assign sda_oe = sda_oe_ff;
   assign buffered_clock_out = clk_out_ff;
   assign mode_boot = (mode_ff == CPM_SELF_BOOT);
   assign mode_i2c = (mode_ff == CPM_HOST_CTRL) && !spi_mode_sel;
   assign mode_spi = (mode_ff == CPM_HOST_CTRL) && spi_mode_sel;
   assign boot_start = boot_start_ff;
   assign i2c_address = i2c_addr_ff;
   assign scl_level = pin_s[CPM_PIN_SCL];
   assign sda_level = pin_s[CPM_PIN_SDA];
   assign spi_rd_take = take_ff;
   assign spi_selected = sel_ff;
   assign spi_read = rd_ff;
   assign spi_byte_valid = byte_valid_ff;
   assign spi_byte = byte_ff;
   assign spi_frame_end = end_ff;

endmodule

/* File: test/cpm_control_port_asserts.sv */
// Concurrent checks on the control port pin mode ports.
`timescale 1ns/1ps

module cpm_control_port_asserts #(
   parameter logic [6:0] I2C_ADDR_BASE = 7'h38
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Pin drives and straps.
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic control_latch,
   input wire logic out_clock_sel_hi,
   input wire logic out_clock_sel_lo,
   input wire logic buffered_clock_out,
   // Core side.
   input wire logic mode_boot,
   input wire logic mode_i2c,
   input wire logic mode_spi,
   input wire logic boot_start,
   input wire logic boot_scl_low,
   input wire logic slave_sda_low,
   input wire logic [6:0] i2c_address,
   input wire logic spi_selected,
   input wire logic spi_byte_valid
);
   //------------------------------------------------------------------
   // Helper logic
   //------------------------------------------------------------------
   logic tog;
   logic last_ff, seen_ff, nxt_seen;
   logic [7:0] run_ff, nxt_run;
   // Cycles since the output clock last changed; first edge is skipped.
   always_comb
   begin
      tog = buffered_clock_out != last_ff;
      nxt_run = tog ? 8'h00 : run_ff + 8'h01;
      nxt_seen = seen_ff | tog;
   end
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         last_ff <= 1'b0;
         run_ff <= 8'h00;
         seen_ff <= 1'b0;
      end
      else
      begin
         last_ff <= buffered_clock_out;
         run_ff <= nxt_run;
         seen_ff <= nxt_seen;
      end
   end
   // The boot start is a lone pulse.
   sequence s_boot_begin;
      boot_start ##1 !boot_start;
   endsequence

   //------------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   a_scl_never_high: assert property (scl_out == 1'b0)
      else $error("scl driven high");
   a_scl_host_input: assert property ((mode_i2c || mode_spi) &&
      $past(mode_i2c || mode_spi) |-> !scl_oe)
      else $error("scl driven outside boot");
   a_scl_boot_drive: assert property (mode_boot && $past(mode_boot)
      |-> scl_oe == $past(boot_scl_low))
      else $error("scl drive does not follow boot master");
   a_sda_i2c_low: assert property (mode_i2c && $past(mode_i2c)
      |-> sda_oe == $past(slave_sda_low) && !sda_out)
      else $error("sda not open collector");
   a_read_out_idle: assert property (mode_spi && control_latch[*8]
      |=> !sda_oe)
      else $error("read pin driven outside frame");
   a_addr_base_bits: assert property (mode_i2c
      |-> i2c_address[6:2] == I2C_ADDR_BASE[6:2])
      else $error("i2c address base wrong");
   a_boot_pulse: assert property (boot_start |-> mode_boot ##0
      s_boot_begin)
      else $error("boot start not a single pulse");
   a_clk_half: assert property (tog && seen_ff |-> run_ff ==
      (8'h01 << {out_clock_sel_hi, out_clock_sel_lo}) - 8'h01)
      else $error("output clock half period wrong");
   a_spi_id_match: assert property (spi_byte_valid
      |-> spi_selected && mode_spi)
      else $error("byte passed for other device");
endmodule

bind cpm_control_port cpm_control_port_asserts #(
   .I2C_ADDR_BASE(I2C_ADDR_BASE)
) chk_u (
   .mclk(mclk), .rst(rst), .scl_out(scl_out), .scl_oe(scl_oe),
   .sda_out(sda_out), .sda_oe(sda_oe), .control_latch(control_latch),
   .out_clock_sel_hi(out_clock_sel_hi),
   .out_clock_sel_lo(out_clock_sel_lo),
   .buffered_clock_out(buffered_clock_out), .mode_boot(mode_boot),
   .mode_i2c(mode_i2c), .mode_spi(mode_spi), .boot_start(boot_start),
   .boot_scl_low(boot_scl_low), .slave_sda_low(slave_sda_low),
   .i2c_address(i2c_address), .spi_selected(spi_selected),
   .spi_byte_valid(spi_byte_valid)
);

/* File: test/cpm_spi_host.sv */
// SPI host model that frames transfers on the control port pins.
`timescale 1ns/1ps

module cpm_spi_host (
   // Pins toward the device.
   output logic sclk,
   output logic latch,
   output logic mosi,
   // Read pin level and strap level shown while idle.
   input wire logic miso,
   input wire logic idle_level
);
   logic in_frame; // High while a frame is open.
   logic mosi_d; // Bit being shifted out.
   // Outside frames the shared pin carries its strap level.
   assign mosi = in_frame ? mosi_d : idle_level;
   // The clock stands still low between frames.
   initial
   begin
      sclk = 1'b0;
      latch = 1'b1;
      in_frame = 1'b0;
      mosi_d = 1'b0;
   end
   // Latch goes low to open a frame.
   task begin_frame;
      latch = 1'b0;
      in_frame = 1'b1;
      #100;
   endtask
   // Latch returns high to close it.
   task end_frame;
      #100;
      latch = 1'b1;
      in_frame = 1'b0;
      #200;
   endtask
   // One byte MSB first at 160 ns; read bit taken late in the high
   // phase because the device answers some clocks after the fall.
   task xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         mosi_d = tx[i];
         #80 sclk = 1'b1;
         #70 rx[i] = miso;
         #10 sclk = 1'b0;
      end
   endtask
endmodule

/* File: test/tb_control_port_pin_modes.sv */
// Self-checking bench for the control port pin mode block.
`timescale 1ns/1ps

module tb_control_port_pin_modes
   import cpm_pkg::*;
;
   logic mclk = 1'b0, rst = 1'b1;
   logic sh = 1'b0, sl = 1'b0, bsel = 1'b0, c1 = 1'b0, c0 = 1'b0;
   logic spi_mode_sel = 1'b0, boot_done = 1'b0;
   logic boot_scl_low = 1'b0, boot_sda_low = 1'b0, slave_sda_low = 1'b0;
   logic [7:0] spi_rd_data = 8'h00;
   logic h_sclk, h_latch, h_mosi;
   logic scl_out, scl_oe, sda_out, sda_oe, bclk, mode_boot, mode_i2c;
   logic mode_spi, boot_start, rd_take, spi_byte_valid;
   logic [6:0] i2c_address;
   logic [7:0] spi_byte;
   logic fe, sel_o, rd_o;
   int n_errors = 0, comparisons = 0, n_boot = 0, n_fe = 0;
   logic [7:0] exp_q[$], rd_q[$]; // Expected bytes and read bytes.
   // Wire levels; SDA has a pull-up, SCL follows the host clock when not driven.
   wire scl_w = scl_oe ? scl_out : h_sclk;
   wire sda_w = sda_oe ? sda_out : 1'b1;

   always #10 mclk = ~mclk;

   cpm_control_port dut_u (.mclk(mclk), .rst(rst), .scl_in(scl_w),
      .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe(sda_oe), .control_latch(h_latch),
      .bus_id_high(h_mosi), .bus_id_low(sl),
      .boot_from_eeprom_select(bsel), .out_clock_sel_hi(c1),
      .out_clock_sel_lo(c0), .buffered_clock_out(bclk),
      .spi_mode_sel(spi_mode_sel), .boot_done(boot_done),
      .mode_boot(mode_boot), .mode_i2c(mode_i2c), .mode_spi(mode_spi),
      .boot_start(boot_start), .boot_scl_low(boot_scl_low),
      .boot_sda_low(boot_sda_low), .slave_sda_low(slave_sda_low),
      .i2c_address(i2c_address), .scl_level(), .sda_level(),
      .spi_rd_data(spi_rd_data), .spi_rd_take(rd_take),
      .spi_selected(sel_o), .spi_read(rd_o),
      .spi_byte_valid(spi_byte_valid),
      .spi_byte(spi_byte), .spi_frame_end(fe));
   cpm_spi_host host_u (.sclk(h_sclk), .latch(h_latch), .mosi(h_mosi),
      .miso(sda_w), .idle_level(sh));

   // Compare one value and count it.
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task step;
      @(posedge mclk);
      #1;
   endtask
   // Verdict and end of run.
   task test_done;
      $display("checks %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Model of the byte stream and of read data handed to the device.
   always @(posedge mclk)
   begin
      if (spi_byte_valid === 1'b1)
         check("byte", spi_byte, exp_q.size() ? exp_q.pop_front() :
            ~spi_byte);
      if (boot_start === 1'b1)
         n_boot++;
      if (fe === 1'b1)
         n_fe++;
      if (rd_take === 1'b1)
      begin
         check("sel_rd", {sel_o, rd_o}, 8'h03);
         rd_q.push_back(spi_rd_data);
         spi_rd_data <= 8'($urandom);
      end
   end
   // Reset with the given boot strap and fresh random other straps held through it.
   task do_reset(input logic boot);
      logic [3:0] st;
      st = 4'($urandom);
      @(posedge mclk);
      rst <= 1'b1;
      bsel <= boot;
      {sh, sl, c1, c0} <= st;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      n_boot = 0;
      repeat (4) step;
   endtask
   // Measure one half period of the output clock.
   task clk_check;
      int n;
      logic v;
      v = bclk;
      n = 0;
      while (bclk === v && n < 40)
      begin
         step;
         n++;
      end
      v = bclk;
      n = 0;
      while (bclk === v && n < 40)
      begin
         step;
         n++;
      end
      check("clk_half", 8'(n), 8'(1 << {c1, c0}));
   endtask
   // One frame: header, two address bytes, n data bytes.
   task frame(input logic own, input logic rd, input int n);
      logic [7:0] rx, b;
      n_fe = 0;
      host_u.begin_frame();
      host_u.xfer({CPM_SPI_ID_BASE[6:1], sl ^ ~own, rd}, rx);
      for (int i = 0; i < n + 2; i++)
      begin
         b = 8'($urandom);
         if (own && (i < 2 || !rd))
            exp_q.push_back(b);
         host_u.xfer(b, rx);
         if (rd && i >= 2)
            check("rd", rx, rd_q.size() ? rd_q.pop_front() : ~rx);
      end
      host_u.end_frame();
      repeat (8) step;
      check("rd_oe", sda_oe, 8'h00);
      check("left", 8'(exp_q.size()), 8'h00);
      check("frame_end", 8'(n_fe), 8'h01);
      rd_q.delete();
   endtask

   initial
   begin
      #1ms;
      n_errors++;
      test_done;
   end
   initial
   begin
      logic [1:0] r;
      void'($urandom(32'h4853_12a4));
      // I2C host mode.
      do_reset(1'b0);
      check("addr", i2c_address, {CPM_I2C_ADDR_BASE[6:2], sh, sl});
      check("i2c", {mode_i2c, mode_boot, 6'(n_boot)}, 8'h80);
      repeat (8)
      begin
         r = 2'($urandom);
         @(posedge mclk);
         slave_sda_low <= r[0];
         boot_scl_low <= r[1];
         step;
         check("sda_oe", sda_oe, r[0]);
         check("scl_oe", scl_oe, 8'h00);
      end
      clk_check;
      $display("i2c test done");
      // SPI host mode: writes, other device, read.
      @(posedge mclk);
      spi_mode_sel <= 1'b1;
      repeat (4) step;
      check("spi", mode_spi, 8'h01);
      for (int n = 1; n <= 3; n++)
         frame(1'b1, 1'b0, n);
      frame(1'b0, 1'b0, 2);
      frame(1'b1, 1'b1, 2);
      $display("spi test done");
      // Self-boot.
      do_reset(1'b1);
      check("boot", {mode_boot, 7'(n_boot)}, 8'h81);
      repeat (8)
      begin
         r = 2'($urandom);
         @(posedge mclk);
         boot_scl_low <= r[0];
         boot_sda_low <= r[1];
         step;
         check("boot_scl", scl_oe, r[0]);
         check("boot_sda", sda_oe, r[1]);
      end
      clk_check;
      @(posedge mclk);
      boot_done <= 1'b1;
      @(posedge mclk);
      boot_done <= 1'b0;
      repeat (3) step;
      check("boot_end", mode_boot, 8'h00);
      $display("boot test done");
      test_done;
   end
endmodule
